// file: hw/serial_param_pkg.sv
// Purpose: shared constants and types of the serial parameter command handler
// Assumes: 250 MHz system clock, 16x oversampled UART
// Notes: command codes double as the parameter offsets
package serial_param_pkg;

  // ==========================================================================
  // clock and timing
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned GUARD_UNIT_MS = 100;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned GUARD_UNIT_CYC = CLK_HZ / MS_PER_S * GUARD_UNIT_MS;
  localparam int unsigned UART_OVERSAMPLE = 16;
  localparam logic [31:0] UART_REF_HZ = 32'(CLK_HZ / UART_OVERSAMPLE);

  // ==========================================================================
  // command codes and parameter offsets
  localparam logic [7:0] OP_AUTO_SRC = 8'h3A;
  localparam logic [7:0] OP_GUARD_AFTER = 8'h05;
  localparam logic [7:0] OP_IF_RATE = 8'h15;
  localparam logic [7:0] OP_EXIT = 8'h09;

  // ==========================================================================
  // reset values and ranges
  localparam logic [15:0] GUARD_AFTER_RST = 16'h000A;
  localparam logic [15:0] GUARD_BEFORE_RST = 16'h000A;
  localparam logic [15:0] GUARD_MIN = 16'h0002;
  localparam logic [7:0] SEQ_CHAR_RST = 8'h2B;
  localparam logic [15:0] RATE_STD_MAX = 16'h0006;
  localparam logic [15:0] RATE_NSTD_MIN = 16'h007D;
  localparam logic [15:0] SRC_ADDR_RST = 16'hFFFF;
  localparam logic [15:0] PARAM_MAX = 16'hFFFF;
  localparam int unsigned STD_RATES = 7;
  localparam int unsigned STD_BPS [STD_RATES] = '{1200, 2400, 4800, 9600, 19200, 38400, 57600};

  // ==========================================================================
  // serial number bits that form the derived source address, and the divider step count
  localparam int unsigned SN_TOP_BIT = 29;
  localparam int unsigned SN_NEXT_BIT = 28;
  localparam int unsigned SN_LOW_MSB = 13;
  localparam int unsigned DIV_STEPS = 32;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_GUARD = 2'b01,
    ST_CMD = 2'b11,
    ST_CALC = 2'b10
  } mode_t;

  // rounded UART divisor for a standard rate code; divides by constants only
  function automatic logic [31:0] std_divisor(input logic [15:0] code);
    logic [31:0] res;
    res = UART_REF_HZ / STD_BPS[0];
    for (int i = 0; i < STD_RATES; i++)
    begin
      if (code == 16'(i))
      begin
        res = (UART_REF_HZ + 32'(STD_BPS[i] / 2)) / 32'(STD_BPS[i]);
      end
    end
    return res;
  endfunction : std_divisor

endpackage : serial_param_pkg

// file: hw/rate_div_if.sv
// Purpose: request and answer path between handler and its divider
// Assumes: one outstanding division at a time
// Notes: done is a one-cycle pulse
`timescale 1ns/10ps
`default_nettype none
interface rate_div_if;
  logic start;
  logic [31:0] dividend;
  logic [31:0] divisor;
  logic done;
  logic [31:0] quotient;
  modport requester (output start, output dividend, output divisor, input done, input quotient);
  modport divider (input start, input dividend, input divisor, output done, output quotient);
endinterface : rate_div_if
`default_nettype wire

// file: hw/rate_divider.sv
// Purpose: sequential restoring divider for rate quantisation
// Assumes: divisor never zero when started
// Notes: answer DIV_STEPS + 1 cycles after start
`timescale 1ns/10ps
`default_nettype none
module rate_divider
  import serial_param_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic srst_i,
  rate_div_if.divider div_if
);

  typedef struct packed {
    logic busy;
    logic [5:0] cnt;
    logic [32:0] rem;
    logic [31:0] quot;
    logic [31:0] den;
    logic done;
  } div_st_t;

  div_st_t st_r;
  div_st_t st_nxt;

  // ==========================================================================
  // one quotient bit per cycle keeps the area small; speed is irrelevant here
  always_comb
  begin
    logic [32:0] shifted;
    shifted = '0;
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    if (srst_i)
    begin
      st_nxt = '0;
    end
    else if (!st_r.busy)
    begin
      if (div_if.start)
      begin
        st_nxt.busy = 1'b1;
        st_nxt.cnt = '0;
        st_nxt.rem = '0;
        st_nxt.quot = div_if.dividend;
        st_nxt.den = div_if.divisor;
      end
    end
    else
    begin
      shifted = {st_r.rem[31:0], st_r.quot[31]};
      st_nxt.quot = {st_r.quot[30:0], 1'b0};
      if (shifted >= {1'b0, st_r.den})
      begin
        shifted = shifted - {1'b0, st_r.den};
        st_nxt.quot[0] = 1'b1;
      end
      st_nxt.rem = shifted;
      st_nxt.cnt = st_r.cnt + 6'h01;
      if (st_r.cnt == 6'(DIV_STEPS - 1))
      begin
        st_nxt.busy = 1'b0;
        st_nxt.done = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    st_r <= st_nxt;
  end

  assign div_if.done = st_r.done;
  assign div_if.quotient = st_r.quot;

endmodule : rate_divider
`default_nettype wire

// file: hw/serial_param_cmd_handler.sv
// Purpose: command-mode entry guard and three parameter commands
// Assumes: commands arrive already decoded from hex text
// Notes: rf_rate_code_i is a strap sampled while srst_i is high
// Behaviour
// - auto-address command overwrites source address
// - address is sn29, sn28, sn13..0
// - guard-after accepts 0x02..0xFFFF, 100 ms units
// - command mode only after guard-after silence
// - default ten units gives one second
// - rate codes 0..6 select standard rates
// - rate values 0x7D..0xFFFF are raw bps
// - new rate applied only at exit
// - radio data rate never changed by rate
// - nonstandard rate stored as nearest achievable
// - rate query returns stored value
// - parameters are hexadecimal on both sides
// - both queries return two bytes
// - rate resets to factory radio rate code
// - guard-before silence checked before sequence character
// - sequence character defaults to plus sign
`timescale 1ns/10ps
`default_nettype none
module serial_param_cmd_handler
  import serial_param_pkg::*;
#(
  parameter int unsigned UNIT_CYCLES = GUARD_UNIT_CYC,
  parameter logic [15:0] GUARD_BEFORE = GUARD_BEFORE_RST,
  parameter logic [7:0] SEQ_CHAR = SEQ_CHAR_RST
)
(
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_byte_i,
  input wire logic cmd_valid_i,
  input wire logic [7:0] cmd_code_i,
  input wire logic cmd_has_param_i,
  input wire logic [15:0] cmd_param_i,
  output logic cmd_ready_o,
  input wire logic [31:0] serial_number_i,
  input wire logic [15:0] rf_rate_code_i,
  output logic rsp_valid_o,
  output logic [15:0] rsp_data_o,
  output logic rsp_err_o,
  output logic cmd_mode_o,
  output logic [15:0] source_address_o,
  output logic [15:0] guard_time_after_o,
  output logic [15:0] active_rate_o,
  output logic [31:0] uart_divisor_o
);

  typedef struct packed {
    mode_t mode;
    logic [31:0] tick;
    logic [15:0] silence;
    logic [15:0] guard_after;
    logic [15:0] rate;
    logic [31:0] divisor;
    logic [15:0] active_rate;
    logic [31:0] active_div;
    logic [15:0] src_addr;
    logic rsp_valid;
    logic [15:0] rsp_data;
    logic rsp_err;
    logic phase;
    logic div_start;
    logic [31:0] div_a;
    logic [31:0] div_b;
  } hnd_st_t;

  hnd_st_t st_r;
  hnd_st_t st_nxt;
  logic accept;
  logic [15:0] auto_addr;

  rate_div_if div_if ();

  rate_divider u_div (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .div_if(div_if)
  );

  function automatic logic [15:0] derive_addr(input logic [31:0] sn);
    return {sn[SN_TOP_BIT], sn[SN_NEXT_BIT], sn[SN_LOW_MSB:0]};
  endfunction : derive_addr

  assign accept = cmd_valid_i && cmd_ready_o;
  assign auto_addr = derive_addr(serial_number_i);

  // ==========================================================================
  // next state
  always_comb
  begin
    logic [31:0] q;
    q = div_if.quotient;
    st_nxt = st_r;
    st_nxt.rsp_valid = 1'b0;
    st_nxt.rsp_err = 1'b0;
    st_nxt.div_start = 1'b0;
    // silence is measured in whole units since the last received byte
    if (rx_valid_i)
    begin
      st_nxt.tick = '0;
      st_nxt.silence = '0;
    end
    else if (st_r.tick == UNIT_CYCLES - 1)
    begin
      st_nxt.tick = '0;
      if (st_r.silence != PARAM_MAX)
      begin
        st_nxt.silence = st_r.silence + 16'h0001;
      end
    end
    else
    begin
      st_nxt.tick = st_r.tick + 32'h0000_0001;
    end
    case (st_r.mode)
      ST_IDLE:
      begin
        if (rx_valid_i && rx_byte_i == SEQ_CHAR && st_r.silence >= GUARD_BEFORE)
        begin
          st_nxt.mode = ST_GUARD;
        end
      end
      ST_GUARD:
      begin
        if (rx_valid_i)
        begin
          st_nxt.mode = ST_IDLE;
        end
        else if (st_r.silence >= st_r.guard_after)
        begin
          st_nxt.mode = ST_CMD;
        end
      end
      ST_CMD:
      begin
        if (accept)
        begin
          st_nxt.rsp_valid = 1'b1;
          st_nxt.rsp_data = '0;
          case (cmd_code_i)
            OP_AUTO_SRC:
            begin
              st_nxt.src_addr = auto_addr;
            end
            OP_GUARD_AFTER:
            begin
              if (!cmd_has_param_i)
              begin
                st_nxt.rsp_data = st_r.guard_after;
              end
              else if (cmd_param_i >= GUARD_MIN)
              begin
                st_nxt.guard_after = cmd_param_i;
              end
              else
              begin
                st_nxt.rsp_err = 1'b1;
              end
            end
            OP_IF_RATE:
            begin
              if (!cmd_has_param_i)
              begin
                st_nxt.rsp_data = st_r.rate;
              end
              else if (cmd_param_i <= RATE_STD_MAX)
              begin
                st_nxt.rate = cmd_param_i;
                st_nxt.divisor = std_divisor(cmd_param_i);
              end
              else if (cmd_param_i >= RATE_NSTD_MIN)
              begin
                // answer deferred until the stored rate is known
                st_nxt.rsp_valid = 1'b0;
                st_nxt.mode = ST_CALC;
                st_nxt.phase = 1'b0;
                st_nxt.div_start = 1'b1;
                st_nxt.div_a = UART_REF_HZ + {17'h0, cmd_param_i[15:1]};
                st_nxt.div_b = {16'h0, cmd_param_i};
              end
              else
              begin
                st_nxt.rsp_err = 1'b1;
              end
            end
            OP_EXIT:
            begin
              st_nxt.active_rate = st_r.rate;
              st_nxt.active_div = st_r.divisor;
              st_nxt.mode = ST_IDLE;
            end
            default:
            begin
              st_nxt.rsp_err = 1'b1;
            end
          endcase
        end
      end
      ST_CALC:
      begin
        if (div_if.done)
        begin
          if (!st_r.phase)
          begin
            // rate that the rounded divisor really produces
            if (q == '0)
            begin
              q = 32'h0000_0001;
            end
            st_nxt.divisor = q;
            st_nxt.phase = 1'b1;
            st_nxt.div_start = 1'b1;
            st_nxt.div_a = UART_REF_HZ + {1'b0, q[31:1]};
            st_nxt.div_b = q;
          end
          else
          begin
            st_nxt.rate = (q > {16'h0, PARAM_MAX}) ? PARAM_MAX : q[15:0];
            st_nxt.rsp_valid = 1'b1;
            st_nxt.rsp_data = '0;
            st_nxt.mode = ST_CMD;
          end
        end
      end
      default:
      begin
        st_nxt.mode = ST_IDLE;
      end
    endcase
    if (srst_i)
    begin
      st_nxt = '0;
      st_nxt.mode = ST_IDLE;
      st_nxt.guard_after = GUARD_AFTER_RST;
      st_nxt.src_addr = SRC_ADDR_RST;
      st_nxt.rate = rf_rate_code_i;
      st_nxt.divisor = std_divisor(rf_rate_code_i);
      st_nxt.active_rate = rf_rate_code_i;
      st_nxt.active_div = std_divisor(rf_rate_code_i);
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    st_r <= st_nxt;
  end

  // ==========================================================================
  // outputs; the radio side has no port here, so its rate cannot move
  assign div_if.start = st_r.div_start;
  assign div_if.dividend = st_r.div_a;
  assign div_if.divisor = st_r.div_b;
  assign cmd_ready_o = (st_r.mode == ST_CMD);
  assign rsp_valid_o = st_r.rsp_valid;
  assign rsp_data_o = st_r.rsp_data;
  assign rsp_err_o = st_r.rsp_err;
  assign cmd_mode_o = (st_r.mode == ST_CMD) || (st_r.mode == ST_CALC);
  assign source_address_o = st_r.src_addr;
  assign guard_time_after_o = st_r.guard_after;
  assign active_rate_o = st_r.active_rate;
  assign uart_divisor_o = st_r.active_div;

  // ==========================================================================
  // checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);

  sequence rate_write_s;
    accept && cmd_code_i == OP_IF_RATE && cmd_has_param_i;
  endsequence

  src_auto_a: assert property (accept && cmd_code_i == OP_AUTO_SRC |=>
    source_address_o == $past(auto_addr)) else $error("auto address not derived");
  guard_range_a: assert property (accept && cmd_code_i == OP_GUARD_AFTER && cmd_has_param_i
    && cmd_param_i < GUARD_MIN |=> rsp_err_o && $stable(guard_time_after_o)) else $error("guard range");
  // a return from the rate calculation is not an entry, so only the guard path is timed
  guard_entry_a: assert property ($rose(st_r.mode == ST_CMD) |->
    $past(st_r.mode) == ST_CALC || $past(st_r.silence) >= $past(st_r.guard_after)) else $error("early command mode");
  seq_before_a: assert property (st_r.mode == ST_IDLE ##1 st_r.mode == ST_GUARD |->
    $past(rx_byte_i) == SEQ_CHAR && $past(st_r.silence) >= GUARD_BEFORE) else $error("bad entry");
  std_store_a: assert property (rate_write_s and cmd_param_i <= RATE_STD_MAX |=>
    st_r.rate == $past(cmd_param_i)) else $error("standard code not stored");
  rate_hold_a: assert property (!$stable(active_rate_o) |->
    $past(accept) && $past(cmd_code_i) == OP_EXIT) else $error("rate applied early");
  nstd_done_a: assert property (rate_write_s and cmd_param_i >= RATE_NSTD_MIN |=>
    ##[60:80] rsp_valid_o) else $error("nonstandard rate not stored");
  rate_query_a: assert property (accept && cmd_code_i == OP_IF_RATE && !cmd_has_param_i |=>
    rsp_valid_o && rsp_data_o == $past(st_r.rate)) else $error("query mismatch");

endmodule : serial_param_cmd_handler
`default_nettype wire

// file: sim/host_link_model.sv
// Purpose: host side of the serial line, sends single bytes and keeps the line quiet
// Assumes: one byte per clock pulse, already framed by the UART
// Notes: a released byte bus shows the inverse of the last byte
`timescale 1ns/10ps
`default_nettype none
module host_link_model #(
  parameter int unsigned UNIT = 8
)
(
  input wire logic clk_i,
  output logic rx_valid_o,
  output logic [7:0] rx_byte_o
);
  initial
  begin
    rx_valid_o = 1'b0;
    rx_byte_o = 8'h00;
  end

  // ==========================================
  // line silence in guard units
  task automatic quiet(input int units);
    repeat (units * UNIT) @(posedge clk_i);
  endtask : quiet

  // ==========================================
  // one received byte
  task automatic send_byte(input logic [7:0] b);
    @(posedge clk_i);
    rx_valid_o <= 1'b1;
    rx_byte_o <= b;
    @(posedge clk_i);
    rx_valid_o <= 1'b0;
    rx_byte_o <= ~b;
  endtask : send_byte
endmodule : host_link_model
`default_nettype wire

// file: sim/test_serial_param_cmd_handler.sv
// Purpose: self-checking bench of the parameter command handler
// Assumes: guard unit shortened to 8 cycles, factory radio rate code 3
// Notes: outputs are sampled on the falling edge, inputs driven on the rising edge
`timescale 1ns/10ps
`default_nettype none
module test_serial_param_cmd_handler;
  import serial_param_pkg::*;
  localparam int unsigned UNIT = 8;
  logic sys_clk_i, srst_i, rx_valid_i, cmd_valid_i, cmd_has_param_i;
  logic [7:0] rx_byte_i, cmd_code_i;
  logic [15:0] cmd_param_i, rsp_data_o, source_address_o, guard_time_after_o, active_rate_o;
  logic cmd_ready_o, rsp_valid_o, rsp_err_o, cmd_mode_o;
  logic [31:0] uart_divisor_o, serial_number_i;
  logic [15:0] rf_rate_code_i;
  int n_errors = 0;
  int tests_run = 0;

  serial_param_cmd_handler #(.UNIT_CYCLES(UNIT)) i_dut (
    .sys_clk_i(sys_clk_i), .srst_i(srst_i), .rx_valid_i(rx_valid_i), .rx_byte_i(rx_byte_i),
    .cmd_valid_i(cmd_valid_i), .cmd_code_i(cmd_code_i), .cmd_has_param_i(cmd_has_param_i),
    .cmd_param_i(cmd_param_i), .cmd_ready_o(cmd_ready_o), .serial_number_i(serial_number_i),
    .rf_rate_code_i(rf_rate_code_i), .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o),
    .rsp_err_o(rsp_err_o), .cmd_mode_o(cmd_mode_o), .source_address_o(source_address_o),
    .guard_time_after_o(guard_time_after_o), .active_rate_o(active_rate_o),
    .uart_divisor_o(uart_divisor_o));

  host_link_model #(.UNIT(UNIT)) i_host (.clk_i(sys_clk_i), .rx_valid_o(rx_valid_i), .rx_byte_o(rx_byte_i));

  // ==========================================
  // helpers
  function automatic logic [31:0] rdiv(input logic [31:0] a, input logic [31:0] b);
    return (a + b / 2) / b;
  endfunction : rdiv

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize;
    if (n_errors == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : summarize

  task automatic expect_mode(input int cyc, input logic m);
    repeat (cyc) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    check(32'(cmd_mode_o), 32'(m));
  endtask : expect_mode

  // one command: held until taken, then the answer is compared
  task automatic cmd(input logic [7:0] c, input logic p, input logic [15:0] v, input logic e,
                     input logic [15:0] d);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    cmd_code_i <= c;
    cmd_has_param_i <= p;
    cmd_param_i <= v;
    cmd_valid_i <= 1'b1;
    @(negedge sys_clk_i);
    while (cmd_ready_o !== 1'b1 && n < 200)
    begin
      @(negedge sys_clk_i);
      n++;
    end
    @(posedge sys_clk_i);
    cmd_valid_i <= 1'b0;
    n = 0;
    @(negedge sys_clk_i);
    while (rsp_valid_o !== 1'b1 && n < 200)
    begin
      @(negedge sys_clk_i);
      n++;
    end
    check(32'(rsp_valid_o), 32'h1);
    check(32'(rsp_err_o), 32'(e));
    if (!e && !p && (c == OP_GUARD_AFTER || c == OP_IF_RATE))
      check(32'(rsp_data_o), 32'(d));
  endtask : cmd

  // ==========================================
  // clock and watchdog
  initial
  begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end

  initial
  begin
    repeat (20000) @(posedge sys_clk_i);
    n_errors++;
    summarize();
  end

  // ==========================================
  // tests
  initial
  begin
    srst_i = 1'b1;
    cmd_valid_i = 1'b0;
    cmd_has_param_i = 1'b0;
    cmd_code_i = 8'h00;
    cmd_param_i = 16'h0000;
    serial_number_i = 32'hEFFF_C123;
    rf_rate_code_i = 16'h0003;
    repeat (3) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    @(negedge sys_clk_i);
    check(32'(active_rate_o), 32'h3);
    check(uart_divisor_o, rdiv(UART_REF_HZ, 32'(STD_BPS[3])));
    check(32'(guard_time_after_o), 32'h000A);
    check(32'(source_address_o), 32'h0000_FFFF);
    check(32'(cmd_ready_o), 32'h0);
    // early and wrong sequence characters must not open command mode
    i_host.quiet(5);
    i_host.send_byte(8'h2B);
    expect_mode(12 * UNIT, 1'b0);
    i_host.send_byte(8'h2A);
    expect_mode(12 * UNIT, 1'b0);
    i_host.send_byte(8'h2B);
    expect_mode(9 * UNIT, 1'b0);
    expect_mode(2 * UNIT, 1'b1);
    cmd(OP_IF_RATE, 1'b0, 16'h0000, 1'b0, 16'h0003);
    cmd(OP_AUTO_SRC, 1'b0, 16'h0000, 1'b0, 16'h0000);
    check(32'(source_address_o), 32'h0000_8123);
    cmd(OP_GUARD_AFTER, 1'b1, 16'h0001, 1'b1, 16'h0000);
    cmd(OP_GUARD_AFTER, 1'b1, 16'hFFFF, 1'b0, 16'h0000);
    cmd(OP_GUARD_AFTER, 1'b0, 16'h0000, 1'b0, 16'hFFFF);
    cmd(OP_GUARD_AFTER, 1'b1, 16'h0002, 1'b0, 16'h0000);
    check(32'(guard_time_after_o), 32'h0002);
    for (int i = 0; i < STD_RATES; i++)
    begin
      cmd(OP_IF_RATE, 1'b1, 16'(i), 1'b0, 16'h0000);
      cmd(OP_IF_RATE, 1'b0, 16'h0000, 1'b0, 16'(i));
    end
    cmd(OP_IF_RATE, 1'b1, 16'h0007, 1'b1, 16'h0000);
    cmd(OP_IF_RATE, 1'b1, 16'h007C, 1'b1, 16'h0000);
    cmd(OP_IF_RATE, 1'b1, 16'hE100, 1'b0, 16'h0000);
    // stored value is the rate that the rounded divisor really gives
    cmd(OP_IF_RATE, 1'b0, 16'h0000, 1'b0,
        16'(rdiv(UART_REF_HZ, rdiv(UART_REF_HZ, 32'hE100))));
    // an unknown code is refused and must not apply the pending rate
    cmd(8'h7F, 1'b0, 16'h0000, 1'b1, 16'h0000);
    check(32'(active_rate_o), 32'h3);
    check(uart_divisor_o, rdiv(UART_REF_HZ, 32'(STD_BPS[3])));
    cmd(OP_EXIT, 1'b0, 16'h0000, 1'b0, 16'h0000);
    check(32'(active_rate_o), 32'h0000_E139);
    check(uart_divisor_o, rdiv(UART_REF_HZ, 32'hE100));
    check(32'(cmd_mode_o), 32'h0);
    // re-entry with the shortest guard
    i_host.quiet(11);
    i_host.send_byte(8'h2B);
    expect_mode(12, 1'b0);
    expect_mode(8, 1'b1);
    cmd(OP_IF_RATE, 1'b1, 16'h0006, 1'b0, 16'h0000);
    cmd(OP_EXIT, 1'b0, 16'h0000, 1'b0, 16'h0000);
    check(32'(active_rate_o), 32'h6);
    check(uart_divisor_o, rdiv(UART_REF_HZ, 32'(STD_BPS[6])));
    // ==========================================
    // mid-run reset with another strap and serial number
    @(posedge sys_clk_i);
    srst_i <= 1'b1;
    rf_rate_code_i <= 16'h0005;
    serial_number_i <= 32'h1000_2ABC;
    repeat (3) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    @(negedge sys_clk_i);
    check(32'(active_rate_o), 32'h5);
    check(uart_divisor_o, rdiv(UART_REF_HZ, 32'(STD_BPS[5])));
    check(32'(guard_time_after_o), 32'h000A);
    check(32'(source_address_o), 32'h0000_FFFF);
    check(32'(cmd_mode_o), 32'h0);
    i_host.quiet(11);
    i_host.send_byte(8'h2B);
    expect_mode(11 * UNIT, 1'b1);
    cmd(OP_IF_RATE, 1'b0, 16'h0000, 1'b0, 16'h0005);
    cmd(OP_AUTO_SRC, 1'b0, 16'h0000, 1'b0, 16'h0000);
    check(32'(source_address_o), 32'h0000_6ABC);
    summarize();
  end
endmodule : test_serial_param_cmd_handler
`default_nettype wire
